// ==== design/cfgr_top.sv ====
// Configuration error restart and start-up sequencer with Avalon-MM registers
// Function
// - Each dual-purpose pin after configuration: user I/O, input, drive low, drive any.
// - Pins unused by the selected scheme default to user I/O after configuration.
// - On a configuration error pull the status line low and reset config logic.
// - Hold the status line low for the reset time-out, then release it.
// - With auto-restart on, restart configuration alone after releasing the status line.
// - Restart only once both the device and configuration device release the line.
// - All general I/O stay high impedance throughout configuration.
// - Release-order off: release I/O tri-states first, then register clears.
// - Release-order on: release register clears first, then I/O tri-states.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module cfgr_top
    import cfgr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    output logic                   irq,
    input  wire logic              cfg_request_n,
    input  wire logic              cfg_status_line_n_i,
    output logic                   cfg_status_line_n_o,
    output logic                   cfg_status_line_n_oe,
    input  wire logic              cfg_data_done,
    input  wire logic              cfg_data_error,
    output logic                   cfg_logic_reset,
    output logic                   io_hold_z,
    output logic                   reg_clear,
    input  wire logic [NUM_DP-1:0] usr_dp_out,
    input  wire logic [NUM_DP-1:0] usr_dp_oe,
    output logic      [NUM_DP-1:0] dp_out,
    output logic      [NUM_DP-1:0] dp_oe
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync_level;
    logic       req_n_s;
    logic       line_s;

    cfgr_sync #(.W (2)) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .pin_in ({cfg_request_n, cfg_status_line_n_i}),
        .level  (sync_level)
    );

    assign req_n_s = sync_level[1];
    assign line_s  = sync_level[0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    cfgr_state_t       state;
    cfgr_state_t       next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              next_status_oe;
    logic              next_logic_reset;
    logic              next_io_hold_z;
    logic              next_reg_clear;
    logic [CTRL_W-1:0] ctrl;
    logic              auto_restart;
    logic              clears_first;
    logic              cfg_writable;

    assign auto_restart = ctrl[CTRL_AUTO_RESTART];
    assign clears_first = ctrl[CTRL_CLEARS_FIRST];
    assign cfg_writable = (state == S_IDLE) || (state == S_HALT);

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            S_IDLE:
            begin
                next_cnt = '0;
                if (req_n_s && line_s)
                    next_state = S_CONFIG;
            end
            S_CONFIG:
            begin
                next_cnt = '0;
                if (cfg_data_error)
                    next_state = S_ERR;
                else if (cfg_data_done)
                    next_state = S_INIT;
            end
            S_INIT:
            begin
                if (cnt == CNT_W'(INIT_GAP_CYC - 1))
                    next_state = S_USER;
                else
                    next_cnt = cnt + CNT_W'(1);
            end
            S_USER:
                next_cnt = '0;
            S_ERR:
            begin
                if (cnt == CNT_W'(ERR_HOLD_CYC - 1))
                begin
                    next_cnt   = '0;
                    next_state = auto_restart ? S_WAIT : S_HALT;
                end
                else
                    next_cnt = cnt + CNT_W'(1);
            end
            S_WAIT:
            begin
                if (line_s)
                    next_state = S_CONFIG;
            end
            S_HALT:
            begin
                if (!req_n_s)
                    next_state = S_IDLE;
            end
            default:
                next_state = S_IDLE;
        endcase
        // A low request aborts any phase except the error hold
        if (!req_n_s && state != S_ERR && state != S_HALT)
        begin
            next_state = S_IDLE;
            next_cnt   = '0;
        end
    end

    always_comb
    begin
        next_status_oe   = (next_state == S_ERR);
        next_logic_reset = (next_state == S_ERR);
        next_io_hold_z   = 1'b1;
        next_reg_clear   = 1'b1;
        if (next_state == S_USER)
        begin
            next_io_hold_z = 1'b0;
            next_reg_clear = 1'b0;
        end
        else if (next_state == S_INIT)
        begin
            next_io_hold_z = clears_first;
            next_reg_clear = !clears_first;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state                <= S_IDLE;
            cnt                  <= '0;
            cfg_status_line_n_o  <= 1'b0;
            cfg_status_line_n_oe <= 1'b0;
            cfg_logic_reset      <= 1'b0;
            io_hold_z            <= 1'b1;
            reg_clear            <= 1'b1;
        end
        else
        begin
            state                <= next_state;
            cnt                  <= next_cnt;
            cfg_status_line_n_o  <= 1'b0;
            cfg_status_line_n_oe <= next_status_oe;
            cfg_logic_reset      <= next_logic_reset;
            io_hold_z            <= next_io_hold_z;
            reg_clear            <= next_reg_clear;
        end
    end

    // ------------------------------------------------------------
    // Dual-purpose pins
    // ------------------------------------------------------------
    logic [2*NUM_DP-1:0] pin_mode;

    cfgr_pins u_pins (
        .clk                   (clk),
        .rstn                  (rstn),
        .io_hold_z             (io_hold_z),
        .passive_serial_scheme (ctrl[CTRL_PASSIVE_SER]),
        .pin_mode              (pin_mode),
        .usr_dp_out            (usr_dp_out),
        .usr_dp_oe             (usr_dp_oe),
        .dp_out                (dp_out),
        .dp_oe                 (dp_oe)
    );

    // ------------------------------------------------------------
    // Register slave and interrupts
    // ------------------------------------------------------------
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [IRQ_W-1:0]    next_irq_stat;
    logic [IRQ_W-1:0]    next_irq_mask;
    logic [IRQ_W-1:0]    irq_evt;
    logic [CTRL_W-1:0]   next_ctrl;
    logic [2*NUM_DP-1:0] next_pin_mode;
    logic [31:0]         next_readdata;
    logic                next_waitrequest;
    logic                next_irq;
    logic                wr_go;
    logic                rd_go;

    assign wr_go = write && !waitrequest;
    assign rd_go = read && waitrequest;

    assign irq_evt[IRQ_DONE]    = (state == S_INIT) && (next_state == S_USER);
    assign irq_evt[IRQ_ERROR]   = (state == S_CONFIG) && (next_state == S_ERR);
    assign irq_evt[IRQ_RESTART] = (state == S_WAIT) && (next_state == S_CONFIG);

    always_comb
    begin
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata    = readdata;
        next_ctrl        = ctrl;
        next_pin_mode    = pin_mode;
        next_irq_mask    = irq_mask;
        next_irq_stat    = irq_stat;
        if (rd_go)
        begin
            case (address)
                OFS_CTRL:     next_readdata = {29'h0, ctrl};
                OFS_PIN_MODE: next_readdata = {16'h0, pin_mode};
                OFS_STATE:    next_readdata = {21'h0, cfg_writable, req_n_s, line_s, 1'b0, state};
                OFS_IRQ_STAT: next_readdata = {29'h0, irq_stat};
                OFS_IRQ_MASK: next_readdata = {29'h0, irq_mask};
                default:      next_readdata = 32'h0;
            endcase
        end
        if (wr_go)
        begin
            case (address)
                OFS_CTRL:
                    if (cfg_writable)
                        next_ctrl = writedata[CTRL_W-1:0];
                OFS_PIN_MODE:
                    if (cfg_writable)
                        next_pin_mode = writedata[2*NUM_DP-1:0];
                OFS_IRQ_STAT: next_irq_stat = irq_stat & ~writedata[IRQ_W-1:0];
                OFS_IRQ_MASK: next_irq_mask = writedata[IRQ_W-1:0];
                default:      next_irq_stat = irq_stat;
            endcase
        end
        // A new event wins over a clear in the same cycle
        next_irq_stat = next_irq_stat | irq_evt;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
            ctrl        <= CTRL_RST;
            pin_mode    <= PIN_MODE_RST;
            irq_mask    <= IRQ_MASK_RST;
            irq_stat    <= '0;
            irq         <= 1'b0;
        end
        else
        begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
            ctrl        <= next_ctrl;
            pin_mode    <= next_pin_mode;
            irq_mask    <= next_irq_mask;
            irq_stat    <= next_irq_stat;
            irq         <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_ERR_PULLS_LOW: assert property (
        (state == S_CONFIG && cfg_data_error && req_n_s)
        |=> cfg_status_line_n_oe && cfg_logic_reset && !cfg_status_line_n_o)
        else $error("error did not pull status line low");

    AST_HOLD_LENGTH: assert property (
        $fell(cfg_status_line_n_oe) |-> $past(cnt) == CNT_W'(ERR_HOLD_CYC - 1))
        else $error("status line released before the reset time-out");

    AST_HOLD_STEADY: assert property (
        (state == S_ERR && cnt != CNT_W'(ERR_HOLD_CYC - 1)) |-> cfg_status_line_n_oe)
        else $error("status line released during error hold");

    AST_AUTO_RESTART: assert property (
        (state == S_WAIT && line_s && req_n_s) |=> state == S_CONFIG ##1 io_hold_z)
        else $error("auto restart did not begin once line was high");

    AST_WAIT_RELEASE: assert property (
        (state == S_WAIT && !line_s) |=> state != S_CONFIG)
        else $error("restart began while status line still low");

    AST_HALT_HOLDS: assert property (
        (state == S_HALT && req_n_s) |=> state == S_HALT)
        else $error("halted sequencer left without request pulse");

    AST_NO_AUTO_OFF: assert property (
        (state == S_ERR && !auto_restart && next_state != S_ERR) |=> state == S_HALT)
        else $error("error with auto restart off did not halt");

    AST_CONFIG_TRISTATE: assert property (
        (state == S_CONFIG || state == S_ERR) |-> io_hold_z && reg_clear)
        else $error("I/O released during configuration");

    AST_ORDER_OFF: assert property (
        ($fell(io_hold_z) && !clears_first) |-> reg_clear ##INIT_GAP_CYC !reg_clear)
        else $error("tri-states not released before clears");

    AST_ORDER_ON: assert property (
        ($fell(reg_clear) && clears_first) |-> io_hold_z ##INIT_GAP_CYC !io_hold_z)
        else $error("clears not released before tri-states");

    AST_STATIC_CFG: assert property (
        (!cfg_writable) |=> $stable(ctrl) && $stable(pin_mode))
        else $error("settings changed during configuration");

    AST_IRQ_LEVEL: assert property (
        (|(irq_evt & irq_mask)) && !(wr_go && address == OFS_IRQ_MASK) |=> irq)
        else $error("interrupt low while unmasked status set");

endmodule : cfgr_top

// ==== inc/cfgr_pkg.sv ====
// Shared constants and types for the configuration restart and start-up controller
package cfgr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ERR_HOLD_NS   = 40000;
    localparam int ERR_HOLD_CYC  = (ERR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_GAP_NS   = 320;
    localparam int INIT_GAP_CYC  = (INIT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 10;

    // ------------------------------------------------------------
    // Dual-purpose pins
    // ------------------------------------------------------------
    localparam int NUM_DP        = 8;
    localparam int SER_UNUSED_LO = 1;
    localparam int SER_UNUSED_HI = 7;

    typedef enum logic [1:0] {
        PM_USER_IO   = 2'h0,
        PM_INPUT_Z   = 2'h1,
        PM_DRIVE_GND = 2'h2,
        PM_DRIVE_ANY = 2'h3
    } cfgr_pin_mode_t;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_PIN_MODE  = 5'h04;
    localparam logic [4:0]  OFS_STATE     = 5'h08;
    localparam logic [4:0]  OFS_IRQ_STAT  = 5'h0C;
    localparam logic [4:0]  OFS_IRQ_MASK  = 5'h10;

    localparam int CTRL_AUTO_RESTART = 0;
    localparam int CTRL_CLEARS_FIRST = 1;
    localparam int CTRL_PASSIVE_SER  = 2;
    localparam int CTRL_W            = 3;

    localparam int STATE_LINE_BIT    = 8;
    localparam int STATE_REQ_BIT     = 9;
    localparam int STATE_WRITABLE    = 10;

    localparam int IRQ_DONE    = 0;
    localparam int IRQ_ERROR   = 1;
    localparam int IRQ_RESTART = 2;
    localparam int IRQ_W       = 3;

    localparam logic [CTRL_W-1:0]   CTRL_RST     = 3'h1;
    localparam logic [2*NUM_DP-1:0] PIN_MODE_RST = 16'h0004;
    localparam logic [IRQ_W-1:0]    IRQ_MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE   = 7'h01,
        S_CONFIG = 7'h02,
        S_INIT   = 7'h04,
        S_USER   = 7'h08,
        S_ERR    = 7'h10,
        S_WAIT   = 7'h20,
        S_HALT   = 7'h40
    } cfgr_state_t;

endpackage : cfgr_pkg

// ==== design/cfgr_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module cfgr_sync
    import cfgr_pkg::*;
#(
    parameter int W = 2
)(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_level;

    // A change counts only once the second and third stages agree
    always_comb
    begin
        next_level = level;
        for (int i = 0; i < W; i++)
        begin
            if (ff2[i] == ff3[i])
                next_level[i] = ff3[i];
        end
    end

    // Lines idle high through their pull-ups
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ff1   <= '1;
            ff2   <= '1;
            ff3   <= '1;
            level <= '1;
        end
        else
        begin
            ff1   <= pin_in;
            ff2   <= ff1;
            ff3   <= ff2;
            level <= next_level;
        end
    end

endmodule : cfgr_sync

// ==== design/cfgr_pins.sv ====
// Dual-purpose configuration pin behaviour after configuration
`timescale 1ns/10ps
module cfgr_pins
    import cfgr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                io_hold_z,
    input  wire logic                passive_serial_scheme,
    input  wire logic [2*NUM_DP-1:0] pin_mode,
    input  wire logic [NUM_DP-1:0]   usr_dp_out,
    input  wire logic [NUM_DP-1:0]   usr_dp_oe,
    output logic      [NUM_DP-1:0]   dp_out,
    output logic      [NUM_DP-1:0]   dp_oe
);

    logic [NUM_DP-1:0] next_dp_out;
    logic [NUM_DP-1:0] next_dp_oe;

    genvar g;
    generate
        for (g = 0; g < NUM_DP; g++)
        begin : g_pin
            cfgr_pin_mode_t eff_mode;

            // Pins the scheme leaves unused fall back to user I/O
            always_comb
            begin
                if (passive_serial_scheme && g >= SER_UNUSED_LO && g <= SER_UNUSED_HI)
                    eff_mode = PM_USER_IO;
                else
                    eff_mode = cfgr_pin_mode_t'(pin_mode[2*g +: 2]);
            end

            always_comb
            begin
                next_dp_out[g] = 1'b0;
                next_dp_oe[g]  = 1'b0;
                if (!io_hold_z)
                begin
                    case (eff_mode)
                        PM_USER_IO:
                        begin
                            next_dp_out[g] = usr_dp_out[g];
                            next_dp_oe[g]  = usr_dp_oe[g];
                        end
                        PM_INPUT_Z:   next_dp_oe[g] = 1'b0;
                        PM_DRIVE_GND: next_dp_oe[g] = 1'b1;
                        PM_DRIVE_ANY:
                        begin
                            next_dp_out[g] = usr_dp_out[g];
                            next_dp_oe[g]  = 1'b1;
                        end
                        default:      next_dp_oe[g] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dp_out <= '0;
            dp_oe  <= '0;
        end
        else
        begin
            dp_out <= next_dp_out;
            dp_oe  <= next_dp_oe;
        end
    end

    AST_PIN_HOLD_Z: assert property (@(posedge clk) disable iff (!rstn)
        io_hold_z |=> dp_oe == '0)
        else $error("dual-purpose pin driven while I/O held in high impedance");

    AST_PIN_SER_USER: assert property (@(posedge clk) disable iff (!rstn)
        (!io_hold_z && passive_serial_scheme)
        |=> dp_oe[SER_UNUSED_HI:SER_UNUSED_LO] == $past(usr_dp_oe[SER_UNUSED_HI:SER_UNUSED_LO]))
        else $error("unused passive serial pin did not follow user I/O");

    AST_PIN_GND: assert property (@(posedge clk) disable iff (!rstn)
        (!io_hold_z && !passive_serial_scheme && pin_mode[5:4] == PM_DRIVE_GND)
        |=> dp_oe[2] && !dp_out[2])
        else $error("pin in ground mode not driving low");

endmodule : cfgr_pins

// ==== verif/cfgr_cdev.sv ====
// Behavioural configuration device sitting on the status line
`timescale 1ns/10ps
module cfgr_cdev
#(
    parameter int HOLD = 40,
    parameter int LOAD = 20
)(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic line_n,
    input  wire logic kick,
    input  wire logic go_err,
    output logic      oe_n,
    output logic      data_done,
    output logic      data_error
);
    logic armed;
    int   hold_cnt;
    int   load_cnt;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {armed, oe_n, data_done, data_error} <= 4'h4;
            hold_cnt <= 0;
            load_cnt <= 0;
        end
        else
        begin
            {data_done, data_error} <= 2'h0;
            if (!line_n && oe_n)
            begin
                // Line pulled low by someone else resets us
                {armed, oe_n} <= 2'h2;
                hold_cnt <= HOLD;
                load_cnt <= 0;
            end
            else if (hold_cnt != 0)
            begin
                hold_cnt <= hold_cnt - 1;
                oe_n <= (hold_cnt == 1);
            end
            else if (kick || armed)
            begin
                armed <= 1'b1;
                load_cnt <= load_cnt + 1;
                if (load_cnt == LOAD)
                begin
                    armed <= 1'b0;
                    load_cnt <= 0;
                    data_error <= go_err;
                    data_done <= !go_err;
                end
            end
        end
    end
endmodule : cfgr_cdev

// ==== verif/cfgr_tb_top.sv ====
// Self-checking testbench for the configuration restart and start-up controller
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module config_error_restart_and_startup_tb_top
    import cfgr_pkg::*;
;
    logic        clk, rstn, read, write, req_n, kick, go_err, wreq, irq;
    logic        st_o, st_oe, done, err, lrst, hz, rclr, cdev_oe_n;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rnd;
    logic [7:0]  uo, ue, dp_out, dp_oe;
    logic [31:0] q[$];
    int          num_errors, n_compared, n;
    wire         line_n = (st_oe ? st_o : 1'b1) && cdev_oe_n;

    cfgr_top i_cfgr_top (.clk(clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(wreq),
        .irq(irq), .cfg_request_n(req_n), .cfg_status_line_n_i(line_n),
        .cfg_status_line_n_o(st_o), .cfg_status_line_n_oe(st_oe), .cfg_data_done(done),
        .cfg_data_error(err), .cfg_logic_reset(lrst), .io_hold_z(hz), .reg_clear(rclr),
        .usr_dp_out(uo), .usr_dp_oe(ue), .dp_out(dp_out), .dp_oe(dp_oe));
    cfgr_cdev i_cfgr_cdev (.clk(clk), .rstn(rstn), .line_n(line_n), .kick(kick),
        .go_err(go_err), .oe_n(cdev_oe_n), .data_done(done), .data_error(err));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Read results are checked against the oldest note
    always @(posedge clk)
        if (read && wreq === 1'b0)
        begin
            `CHK(readdata, q[0])
            void'(q.pop_front());
        end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {write, read, address, writedata} <= {w, !w, a, d};
        do @(posedge clk); while (wreq !== 1'b0);
        {write, read} <= 2'h0;
    endtask : bus

    task rd(input logic [4:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task run(input logic [2:0] ctrl, input logic e);
        logic [15:0] pm;
        logic [1:0]  md;
        @(posedge clk);
        req_n <= 1'b0;
        cyc(6);
        rnd = lfsr(rnd);
        pm = {rnd[7:0], 8'hE4};
        {uo, ue} <= rnd[31:16];
        bus(1'b1, OFS_CTRL, {29'h0, ctrl});
        bus(1'b1, OFS_PIN_MODE, {16'h0, pm});
        rd(OFS_CTRL, {29'h0, ctrl});
        rd(OFS_PIN_MODE, {16'h0, pm});
        {go_err, req_n, kick} <= {e, 2'b11};
        @(posedge clk);
        kick <= 1'b0;
        cyc(8);
        `CHK({hz, dp_oe}, 9'h100)
        if (e)
        begin
            repeat (3000) if (st_oe !== 1'b1) @(posedge clk);
            go_err <= 1'b0;
            `CHK(lrst, 1'b1)
            n = 0;
            repeat (1100) if (st_oe === 1'b1) begin @(posedge clk); n++; end
            `CHK(n, ERR_HOLD_CYC)
            if (ctrl[0])
                rd(OFS_STATE, 32'h220);
            else
            begin
                cyc(60);
                rd(OFS_STATE, 32'h740);
                req_n <= 1'b0;
                cyc(6);
                {req_n, kick} <= 2'b11;
                @(posedge clk);
                kick <= 1'b0;
            end
        end
        repeat (3000) if ((hz & rclr) === 1'b1) @(posedge clk);
        `CHK({hz, rclr}, ctrl[1] ? 2'b10 : 2'b01)
        cyc(12);
        rd(OFS_STATE, 32'h308);
        bus(1'b1, OFS_CTRL, 32'h0);
        rd(OFS_CTRL, {29'h0, ctrl});
        rd(OFS_IRQ_STAT, e ? {29'h0, ctrl[0], 2'b11} : 32'h1);
        `CHK(irq, 1'b1)
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        rd(OFS_IRQ_STAT, 32'h0);
        `CHK(irq, 1'b0)
        for (int i = 0; i < NUM_DP; i++)
        begin
            md = (ctrl[2] && i >= SER_UNUSED_LO && i <= SER_UNUSED_HI) ? 2'h0 : pm[2*i+:2];
            case (md)
                2'h0: `CHK(dp_oe[i], ue[i])
                2'h1: `CHK(dp_oe[i], 1'b0)
                2'h2: `CHK({dp_oe[i], dp_out[i]}, 2'b10)
                default: `CHK({dp_oe[i], dp_out[i]}, {1'b1, uo[i]})
            endcase
        end
    endtask : run

    task give_verdict;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    initial
    begin
        {rstn, read, write, req_n, kick, go_err, address, writedata, uo, ue} = '0;
        {num_errors, n_compared} = '0;
        rnd = 32'h2fc1;
        cyc(6);
        rstn <= 1'b1;
        rd(OFS_CTRL, {29'h0, CTRL_RST});
        rd(OFS_PIN_MODE, {16'h0, PIN_MODE_RST});
        rd(OFS_IRQ_MASK, 32'h0);
        rd(5'h14, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h7);
        run(3'h1, 1'b0);
        run(3'h6, 1'b0);
        run(3'h1, 1'b1);
        run(3'h6, 1'b1);
        give_verdict;
    end

    initial
    begin
        #(40 * 40000);
        num_errors++;
        give_verdict;
    end
endmodule : config_error_restart_and_startup_tb_top
